// ==== irdv_ctx.sv ====
// One receive context: payload strip, frame start detection and frame sync gating
`timescale 1ns/1ps
`default_nettype none
module irdv_ctx
   import irdv_pkg::*;
(
   input  wire logic        sys_clk,
   input  wire logic        reset_n,
   input  wire logic        strip_en,
   input  wire logic        sync_en,
   input  wire logic        pkt_start,
   input  wire logic        quad_valid,
   input  wire logic [31:0] quad_data,
   input  wire logic        frame_end,
   output logic             quad_keep,
   output logic             sof_seen,
   output logic             out_of_place
);
   logic [1:0] qidx_r;
   logic       synced_r;
   logic       mid_frame_r;
   logic       is_sof;

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         qidx_r <= 2'h0;
      end else if (pkt_start) begin
         qidx_r <= 2'h0;
      end else if (quad_valid && qidx_r != 2'h3) begin
         qidx_r <= qidx_r + 2'h1;
      end
   end

   assign is_sof = quad_valid && qidx_r == IRDV_SOF_QUADLET
                   && quad_data[31:24] == IRDV_SOF_BYTE0
                   && quad_data[19:16] == IRDV_SOF_NIB1;

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         synced_r    <= 1'b0;
         mid_frame_r <= 1'b0;
      end else if (!sync_en) begin
         synced_r    <= 1'b0;
         mid_frame_r <= 1'b0;
      end else if (is_sof) begin
         synced_r    <= 1'b1;
         mid_frame_r <= 1'b1;
      end else if (frame_end) begin
         mid_frame_r <= 1'b0;
      end
   end

   always_comb begin
      quad_keep    = quad_valid;
      if (strip_en && qidx_r < IRDV_STRIP_QUADLETS) begin
         quad_keep = 1'b0;
      end
      if (sync_en && !synced_r && !is_sof) begin
         quad_keep = 1'b0;
      end
      sof_seen     = is_sof;
      out_of_place = sync_en && is_sof && mid_frame_r;
   end
endmodule
`default_nettype wire

// ==== irdv_pkg.sv ====
// Package: register map, field layout and constants of the receive video enhancement block
package irdv_pkg;
   localparam int          IRDV_NUM_CTX         = 4;
   localparam logic [11:0] IRDV_OFS_SET         = 12'ha80;
   localparam logic [11:0] IRDV_OFS_CLEAR       = 12'ha84;
   localparam logic [31:0] IRDV_RESET_VALUE     = 32'h0000_0000;
   // Writable bits: strip at 0/4/8/12, frame sync at 1/5/9/13
   localparam logic [31:0] IRDV_WRITE_MASK      = 32'h0000_3333;
   localparam int          IRDV_CTX_STRIDE      = 4;
   localparam int          IRDV_STRIP_POS       = 0;
   localparam int          IRDV_SYNC_POS        = 1;
   // Receive context control register pairs (set/clear) that supply isochHeader
   localparam logic [11:0] IRDV_CTXCTL_BASE     = 12'h400;
   localparam logic [11:0] IRDV_CTXCTL_STEP     = 12'h020;
   localparam int          IRDV_ISOCH_HDR_POS   = 30;
   localparam int          IRDV_ACTIVE_POS      = 10;
   localparam int          IRDV_RUN_POS         = 15;
   // Buffer-fill descriptor branch field that enables frame sync
   localparam logic [1:0]  IRDV_BRANCH_SYNC     = 2'h1;
   // Frame start tag: first byte and low nibble of second byte of quadlet 3
   localparam logic [7:0]  IRDV_SOF_BYTE0       = 8'h1f;
   localparam logic [3:0]  IRDV_SOF_NIB1        = 4'h7;
   localparam logic [1:0]  IRDV_SOF_QUADLET     = 2'h2;
   localparam logic [1:0]  IRDV_STRIP_QUADLETS  = 2'h2;
   // Packet scan states of one context
   typedef enum logic [1:0] {IRDV_IDLE, IRDV_HUNT, IRDV_PASS} irdv_sync_t;
endpackage

// ==== irdv_pkt_src.sv ====
// Packet feed model standing in for the isochronous receive stream of four contexts
`timescale 1ns/1ps
`default_nettype none
module irdv_pkt_src (
   input  wire logic         sys_clk,
   output logic      [3:0]   pkt_start,
   output logic      [3:0]   quad_valid,
   output logic      [127:0] quad_data,
   output logic      [3:0]   frame_end
);
   initial {pkt_start, quad_valid, quad_data, frame_end} = '0;
   // One packet of n quadlets, quadlet index 2 carries tag
   task automatic send(input int c, input logic [31:0] tag, input int n);
      @(posedge sys_clk);
      #1 pkt_start[c] = 1'b1;
      for (int i = 0; i < n; i++) begin
         @(posedge sys_clk);
         #1 pkt_start[c] = 1'b0;
         quad_valid[c] = 1'b1;
         quad_data[32*c +: 32] = (i == 2) ? tag : 32'h0100_0000 + i;
      end
      @(posedge sys_clk);
      #1 quad_valid[c] = 1'b0;
      // Released data lines show the inverse, never the stale quadlet
      quad_data[32*c +: 32] = ~quad_data[32*c +: 32];
   endtask
   task automatic end_frame(input int c);
      @(posedge sys_clk);
      #1 frame_end[c] = 1'b1;
      @(posedge sys_clk);
      #1 frame_end[c] = 1'b0;
   endtask
endmodule
`default_nettype wire

// ==== irdv_top.sv ====
// Receive video enhancement control word with set/clear aliases and four contexts
// How it works
// - Set alias sets written ones, clear alias clears them; both read the word.
// - The whole control word is zero after reset.
// - Bits 31-14, 11-10, 7-6 and 3-2 always read zero.
// - Strip bit makes the context drop the first two payload quadlets.
// - Strip acts only while that context's isochHeader bit is zero.
// - Frame sync in buffer-fill with branch 01b waits for a frame start tag.
// - Frame start tag out of place sends the context to the frameBranch descriptor.
// - Frame sync acts only with strip set and isochHeader zero.
// - isochHeader of contexts 0-3 comes from control registers at 400h, 420h, 440h, 460h.
// - Frame start is quadlet three beginning 1Fh then a byte ending in 7h.
// - With frame sync on, no data moves to buffers before a frame start.
`timescale 1ns/1ps
`default_nettype none
module irdv_top
   import irdv_pkg::*;
#(
   parameter int NCTX = IRDV_NUM_CTX
)
(
   input  wire logic              sys_clk,
   input  wire logic              reset_n,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   input  wire logic [11:0]       reg_addr,
   input  wire logic [31:0]       reg_wdata,
   output logic      [31:0]       reg_rdata,
   input  wire logic [NCTX-1:0]   ctx_isoch_header,
   input  wire logic [NCTX-1:0]   ctx_active,
   input  wire logic [NCTX-1:0]   ctx_run,
   input  wire logic [NCTX-1:0]   ctx_buffer_fill,
   input  wire logic [2*NCTX-1:0] ctx_branch,
   input  wire logic [NCTX-1:0]   pkt_start,
   input  wire logic [NCTX-1:0]   quad_valid,
   input  wire logic [32*NCTX-1:0] quad_data,
   input  wire logic [NCTX-1:0]   frame_end,
   output logic      [NCTX-1:0]   quad_keep,
   output logic      [NCTX-1:0]   sof_detect,
   output logic      [NCTX-1:0]   frame_branch_take,
   output logic      [NCTX-1:0]   strip_active,
   output logic      [NCTX-1:0]   sync_active
);
   logic [31:0]     enh_r;
   logic [NCTX-1:0] strip_eff;
   logic [NCTX-1:0] sync_eff;
   logic [NCTX-1:0] keep_c;
   logic [NCTX-1:0] sof_c;
   logic [NCTX-1:0] oop_c;

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!reset_n);

   // Register offset of a context's control register pair (set alias)
   function automatic logic [11:0] ctxctl_ofs(input int c);
      ctxctl_ofs = IRDV_CTXCTL_BASE + 12'(c) * IRDV_CTXCTL_STEP;
   endfunction

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         enh_r <= IRDV_RESET_VALUE;
      end else if (reg_wr && reg_addr == IRDV_OFS_SET) begin
         enh_r <= enh_r | (reg_wdata & IRDV_WRITE_MASK);
      end else if (reg_wr && reg_addr == IRDV_OFS_CLEAR) begin
         enh_r <= enh_r & ~(reg_wdata & IRDV_WRITE_MASK);
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         reg_rdata <= 32'h0000_0000;
      end else if (reg_rd && (reg_addr == IRDV_OFS_SET || reg_addr == IRDV_OFS_CLEAR)) begin
         reg_rdata <= enh_r & IRDV_WRITE_MASK;
      end else begin
         reg_rdata <= 32'h0000_0000;
      end
   end

   genvar g;
   generate
      for (g = 0; g < NCTX; g++) begin : g_ctx
         localparam int SB = g * IRDV_CTX_STRIDE + IRDV_STRIP_POS;
         localparam int FB = g * IRDV_CTX_STRIDE + IRDV_SYNC_POS;
         // Isoch header input of context g is the one mapped at ctxctl_ofs(g)
         assign strip_eff[g] = enh_r[SB] && !ctx_isoch_header[g];
         assign sync_eff[g]  = enh_r[FB] && strip_eff[g] && ctx_buffer_fill[g]
                               && ctx_branch[2*g +: 2] == IRDV_BRANCH_SYNC;
         irdv_ctx u_ctx (
            .sys_clk      (sys_clk),
            .reset_n      (reset_n),
            .strip_en     (strip_eff[g]),
            .sync_en      (sync_eff[g]),
            .pkt_start    (pkt_start[g]),
            .quad_valid   (quad_valid[g]),
            .quad_data    (quad_data[32*g +: 32]),
            .frame_end    (frame_end[g]),
            .quad_keep    (keep_c[g]),
            .sof_seen     (sof_c[g]),
            .out_of_place (oop_c[g])
         );
      end
   endgenerate

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         quad_keep         <= '0;
         sof_detect        <= '0;
         frame_branch_take <= '0;
         strip_active      <= '0;
         sync_active       <= '0;
      end else begin
         quad_keep         <= keep_c;
         sof_detect        <= sof_c;
         frame_branch_take <= oop_c;
         strip_active      <= strip_eff;
         sync_active       <= sync_eff;
      end
   end

   // Per-context enhancement fields of the control word
   logic payload_header_strip_ctx0;
   logic payload_header_strip_ctx1;
   logic payload_header_strip_ctx2;
   logic payload_header_strip_ctx3;
   logic frame_sync_branch_ctx0;
   logic frame_sync_branch_ctx1;
   logic frame_sync_branch_ctx2;
   logic frame_sync_branch_ctx3;
   assign payload_header_strip_ctx0 = enh_r[0];
   assign payload_header_strip_ctx1 = enh_r[4];
   assign payload_header_strip_ctx2 = enh_r[8];
   assign payload_header_strip_ctx3 = enh_r[12];
   assign frame_sync_branch_ctx0    = enh_r[1];
   assign frame_sync_branch_ctx1    = enh_r[5];
   assign frame_sync_branch_ctx2    = enh_r[9];
   assign frame_sync_branch_ctx3    = enh_r[13];

   a_reset_zero: assert property (@(posedge sys_clk) $rose(reset_n) |-> enh_r == 32'h0)
      else $error("control word not zero after reset");
   a_rsvd_zero: assert property (@(posedge sys_clk) disable iff (!reset_n)
      (enh_r & ~IRDV_WRITE_MASK) == 32'h0 && (reg_rdata & ~IRDV_WRITE_MASK) == 32'h0)
      else $error("reserved bit set");
   a_set_alias: assert property (@(posedge sys_clk) disable iff (!reset_n)
      reg_wr && reg_addr == IRDV_OFS_SET |=> (enh_r & ($past(reg_wdata) & IRDV_WRITE_MASK))
      == ($past(reg_wdata) & IRDV_WRITE_MASK))
      else $error("set alias failed");
   a_clear_alias: assert property (@(posedge sys_clk) disable iff (!reset_n)
      reg_wr && reg_addr == IRDV_OFS_CLEAR |=> (enh_r & $past(reg_wdata)) == 32'h0)
      else $error("clear alias failed");
   a_zero_keeps: assert property (@(posedge sys_clk) disable iff (!reset_n)
      reg_wr && reg_addr == IRDV_OFS_SET |=> (enh_r & ~$past(reg_wdata)) ==
      ($past(enh_r) & ~$past(reg_wdata)))
      else $error("unselected bits changed");
   a_read_back: assert property (@(posedge sys_clk) disable iff (!reset_n)
      reg_rd && reg_addr == IRDV_OFS_CLEAR |=> reg_rdata == $past(enh_r))
      else $error("read back mismatch");
   a_strip_gate: assert property (@(posedge sys_clk) disable iff (!reset_n)
      ctx_isoch_header[0] |=> !strip_active[0])
      else $error("strip active with isoch header");
   a_sync_gate: assert property (@(posedge sys_clk) disable iff (!reset_n)
      !enh_r[0] |=> !sync_active[0])
      else $error("sync active without strip");
   a_ctx1_sync: assert property (@(posedge sys_clk) disable iff (!reset_n)
      reg_wr && reg_addr == IRDV_OFS_SET && reg_wdata[5] |=> enh_r[5])
      else $error("context 1 sync bit not set");
   a_strip_drop: assert property (@(posedge sys_clk) disable iff (!reset_n)
      strip_eff[0] && pkt_start[0] ##1 quad_valid[0] |=> !quad_keep[0])
      else $error("first quadlet kept while stripping");
   a_branch_sof: assert property (@(posedge sys_clk) disable iff (!reset_n)
      frame_branch_take[0] |-> $past(sof_c[0]) && $past(sync_eff[0]))
      else $error("branch without frame start");
   a_write_only: assert property (@(posedge sys_clk) disable iff (!reset_n)
      $changed(enh_r) |-> $past(reg_wr))
      else $error("control word changed without a write");

   // Register bus side checks
   a_rdata_idle: assert property (
      !reg_rd |=> reg_rdata == 32'h0000_0000)
      else $error("read data without a read");
   a_other_write: assert property (
      reg_wr && reg_addr != IRDV_OFS_SET && reg_addr != IRDV_OFS_CLEAR |=> $stable(enh_r))
      else $error("write to other offset changed the word");

   // Strip gating and sync-needs-strip gating of contexts 1 to 3
   a_strip_gate1: assert property (
      ctx_isoch_header[1] |=> !strip_active[1])
      else $error("strip active with isoch header");
   a_strip_gate2: assert property (
      ctx_isoch_header[2] |=> !strip_active[2])
      else $error("strip active with isoch header");
   a_strip_gate3: assert property (
      ctx_isoch_header[3] |=> !strip_active[3])
      else $error("strip active with isoch header");
   a_sync_gate1: assert property (
      !payload_header_strip_ctx1 |=> !sync_active[1])
      else $error("sync active without strip");
   a_sync_gate2: assert property (
      !payload_header_strip_ctx2 |=> !sync_active[2])
      else $error("sync active without strip");
   a_sync_gate3: assert property (
      !payload_header_strip_ctx3 |=> !sync_active[3])
      else $error("sync active without strip");

   // Frame sync needs isoch header clear, buffer fill, branch 01b and its own bit
   a_sync_hdr0: assert property (
      ctx_isoch_header[0] |=> !sync_active[0])
      else $error("sync active with isoch header");
   a_sync_hdr1: assert property (
      ctx_isoch_header[1] |=> !sync_active[1])
      else $error("sync active with isoch header");
   a_sync_hdr2: assert property (
      ctx_isoch_header[2] |=> !sync_active[2])
      else $error("sync active with isoch header");
   a_sync_hdr3: assert property (
      ctx_isoch_header[3] |=> !sync_active[3])
      else $error("sync active with isoch header");
   a_sync_fill0: assert property (
      !ctx_buffer_fill[0] |=> !sync_active[0])
      else $error("sync active outside buffer fill");
   a_sync_fill1: assert property (
      !ctx_buffer_fill[1] |=> !sync_active[1])
      else $error("sync active outside buffer fill");
   a_sync_fill2: assert property (
      !ctx_buffer_fill[2] |=> !sync_active[2])
      else $error("sync active outside buffer fill");
   a_sync_fill3: assert property (
      !ctx_buffer_fill[3] |=> !sync_active[3])
      else $error("sync active outside buffer fill");
   a_sync_code0: assert property (
      ctx_branch[1:0] != IRDV_BRANCH_SYNC |=> !sync_active[0])
      else $error("sync active with wrong branch code");
   a_sync_code1: assert property (
      ctx_branch[3:2] != IRDV_BRANCH_SYNC |=> !sync_active[1])
      else $error("sync active with wrong branch code");
   a_sync_code2: assert property (
      ctx_branch[5:4] != IRDV_BRANCH_SYNC |=> !sync_active[2])
      else $error("sync active with wrong branch code");
   a_sync_code3: assert property (
      ctx_branch[7:6] != IRDV_BRANCH_SYNC |=> !sync_active[3])
      else $error("sync active with wrong branch code");
   a_sync_bit0: assert property (
      !frame_sync_branch_ctx0 |=> !sync_active[0])
      else $error("sync active without its bit");
   a_sync_bit1: assert property (
      !frame_sync_branch_ctx1 |=> !sync_active[1])
      else $error("sync active without its bit");
   a_sync_bit2: assert property (
      !frame_sync_branch_ctx2 |=> !sync_active[2])
      else $error("sync active without its bit");
   a_sync_bit3: assert property (
      !frame_sync_branch_ctx3 |=> !sync_active[3])
      else $error("sync active without its bit");

   // Data path of every context
   a_strip_drop1: assert property (
      strip_eff[1] && pkt_start[1] ##1 quad_valid[1] |=> !quad_keep[1])
      else $error("first quadlet kept while stripping");
   a_strip_drop2: assert property (
      strip_eff[2] && pkt_start[2] ##1 quad_valid[2] |=> !quad_keep[2])
      else $error("first quadlet kept while stripping");
   a_strip_drop3: assert property (
      strip_eff[3] && pkt_start[3] ##1 quad_valid[3] |=> !quad_keep[3])
      else $error("first quadlet kept while stripping");
   a_keep_valid0: assert property (
      quad_keep[0] |-> $past(quad_valid[0]))
      else $error("kept without quadlet");
   a_keep_valid1: assert property (
      quad_keep[1] |-> $past(quad_valid[1]))
      else $error("kept without quadlet");
   a_keep_valid2: assert property (
      quad_keep[2] |-> $past(quad_valid[2]))
      else $error("kept without quadlet");
   a_keep_valid3: assert property (
      quad_keep[3] |-> $past(quad_valid[3]))
      else $error("kept without quadlet");
   a_sof_tag0: assert property (
      sof_detect[0] |-> $past(quad_data[31:24]) == IRDV_SOF_BYTE0)
      else $error("frame start without tag byte");
   a_sof_tag1: assert property (
      sof_detect[1] |-> $past(quad_data[63:56]) == IRDV_SOF_BYTE0)
      else $error("frame start without tag byte");
   a_sof_tag2: assert property (
      sof_detect[2] |-> $past(quad_data[95:88]) == IRDV_SOF_BYTE0)
      else $error("frame start without tag byte");
   a_sof_tag3: assert property (
      sof_detect[3] |-> $past(quad_data[127:120]) == IRDV_SOF_BYTE0)
      else $error("frame start without tag byte");
   a_branch_sof1: assert property (
      frame_branch_take[1] |-> $past(sof_c[1]) && $past(sync_eff[1]))
      else $error("branch without frame start");
   a_branch_sof2: assert property (
      frame_branch_take[2] |-> $past(sof_c[2]) && $past(sync_eff[2]))
      else $error("branch without frame start");
   a_branch_sof3: assert property (
      frame_branch_take[3] |-> $past(sof_c[3]) && $past(sync_eff[3]))
      else $error("branch without frame start");

   c_set: cover property (@(posedge sys_clk) reg_wr && reg_addr == IRDV_OFS_SET);
   c_clear: cover property (@(posedge sys_clk) reg_wr && reg_addr == IRDV_OFS_CLEAR);
   c_sof: cover property (@(posedge sys_clk) sof_detect[0] && sync_active[0]);
   c_branch: cover property (@(posedge sys_clk) frame_branch_take != '0);
   c_strip: cover property (@(posedge sys_clk) strip_active[0] && quad_keep[0]);
endmodule
`default_nettype wire

// ==== tb_iso_rx_dv_frame_sync_ctrl.sv ====
// Self-checking bench for the receive video enhancement block
`timescale 1ns/1ps
`default_nettype none
module tb_iso_rx_dv_frame_sync_ctrl;
   import irdv_pkg::*;
   logic sys_clk = 1'b0;
   logic reset_n = 1'b0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [11:0] reg_addr = '0;
   logic [31:0] reg_wdata = '0;
   logic [31:0] reg_rdata;
   logic [3:0] isoch = '0, act = '0, bfill = '0;
   logic [7:0] branch = '0;
   logic [3:0] pkt_start, quad_valid, frame_end, keep, sof, fbr, strip_act, sync_act;
   logic [127:0] quad_data;
   int num_errors = 0, compares = 0;
   int keep_cnt[4], sof_cnt[4], br_cnt[4];
   always #5 sys_clk = ~sys_clk;
   irdv_top irdv_top_inst (.sys_clk(sys_clk), .reset_n(reset_n), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .ctx_isoch_header(isoch), .ctx_active(act), .ctx_run(act), .ctx_buffer_fill(bfill),
      .ctx_branch(branch), .pkt_start(pkt_start), .quad_valid(quad_valid),
      .quad_data(quad_data), .frame_end(frame_end), .quad_keep(keep), .sof_detect(sof),
      .frame_branch_take(fbr), .strip_active(strip_act), .sync_active(sync_act));
   irdv_pkt_src irdv_pkt_src_inst (.sys_clk(sys_clk), .pkt_start(pkt_start),
      .quad_valid(quad_valid), .quad_data(quad_data), .frame_end(frame_end));
   always @(posedge sys_clk) begin
      for (int c = 0; c < 4; c++) begin
         keep_cnt[c] += int'(keep[c] === 1'b1);
         sof_cnt[c] += int'(sof[c] === 1'b1);
         br_cnt[c] += int'(fbr[c] === 1'b1);
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      #1 reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      @(posedge sys_clk);
      #1 reg_wr = 1'b0;
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] exp);
      @(posedge sys_clk);
      #1 reg_rd = 1'b1;
      reg_addr = a;
      @(posedge sys_clk);
      #1 reg_rd = 1'b0;
      chk(reg_rdata, exp);
   endtask
   // Counts of kept, frame start and branch pulses since the last call
   task automatic cnt(input int c, input int k, input int s, input int b);
      repeat (2) @(posedge sys_clk);
      #1 chk(32'(keep_cnt[c]), 32'(k));
      chk(32'(sof_cnt[c]), 32'(s));
      chk(32'(br_cnt[c]), 32'(b));
      keep_cnt = '{default: 0};
      sof_cnt = '{default: 0};
      br_cnt = '{default: 0};
   endtask
   task automatic results();
      $display("compares %0d errors %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge sys_clk);
      num_errors++;
      results();
   end
   initial begin
      keep_cnt = '{default: 0};
      sof_cnt = '{default: 0};
      br_cnt = '{default: 0};
      repeat (20) @(posedge sys_clk);
      #1 reset_n = 1'b1;
      rd(IRDV_OFS_SET, 32'h0000_0000);
      rd(IRDV_OFS_CLEAR, 32'h0000_0000);
      wr(IRDV_OFS_SET, 32'hffff_ffff);
      rd(IRDV_OFS_SET, 32'h0000_3333);
      wr(IRDV_OFS_CLEAR, 32'hffff_cc22);
      rd(IRDV_OFS_CLEAR, 32'h0000_3311);
      wr(IRDV_OFS_SET, 32'h0000_0020);
      rd(IRDV_OFS_SET, 32'h0000_3331);
      rd(12'ha88, 32'h0000_0000);
      wr(IRDV_OFS_CLEAR, 32'hffff_ffff);
      wr(IRDV_OFS_SET, 32'h0000_1111);
      rd(IRDV_OFS_SET, 32'h0000_1111);
      $display("register test done");
      isoch = 4'b0010;
      act = 4'hf;
      repeat (2) @(posedge sys_clk);
      #1 chk(32'(strip_act), 32'h0000_000d);
      irdv_pkt_src_inst.send(0, 32'h1fa7_0000, 4);
      cnt(0, 2, 1, 0);
      irdv_pkt_src_inst.send(1, 32'h1fa7_0000, 4);
      cnt(1, 4, 1, 0);
      $display("strip test done");
      act = 4'h0;
      bfill = 4'b0111;
      branch = 8'b00_00_01_01;
      wr(IRDV_OFS_SET, 32'h0000_2222);
      act = 4'hf;
      repeat (2) @(posedge sys_clk);
      #1 chk(32'(sync_act), 32'h0000_0001);
      irdv_pkt_src_inst.send(2, 32'h0000_0000, 4);
      cnt(2, 2, 0, 0);
      irdv_pkt_src_inst.send(0, 32'h0000_0000, 4);
      cnt(0, 0, 0, 0);
      irdv_pkt_src_inst.send(0, 32'h1f16_0000, 4);
      cnt(0, 0, 0, 0);
      irdv_pkt_src_inst.send(0, 32'h1fa7_0000, 4);
      cnt(0, 2, 1, 0);
      irdv_pkt_src_inst.send(0, 32'h1f57_0000, 4);
      cnt(0, 2, 1, 1);
      irdv_pkt_src_inst.end_frame(0);
      irdv_pkt_src_inst.send(0, 32'h1f07_0000, 4);
      cnt(0, 2, 1, 0);
      $display("frame sync test done");
      results();
   end
endmodule
`default_nettype wire
